/* ahj_pkg.sv */
// Purpose: shared constants and types for the alarm history and jog panel logic
// Assumes: 32-bit AXI4-Lite register access, one 10 MHz clock
// Notes: alarm codes are kept as two hex digits of the displayed code
package ahj_pkg;
  // history geometry
  localparam int HIST_DEPTH = 10;
  localparam int CODE_W = 8;
  localparam int CONST_W = 16;
  // byte offsets of the register map
  localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
  localparam logic [7:0] OFS_FUNC_CTRL = 8'h04;
  localparam logic [7:0] OFS_JOG_SPEED = 8'h08;
  localparam logic [7:0] OFS_TORQUE_LVL = 8'h0c;
  localparam logic [7:0] OFS_SPEED_LVL = 8'h10;
  localparam logic [7:0] OFS_ACCEL_LVL = 8'h14;
  localparam logic [7:0] OFS_ERR_LVL = 8'h18;
  localparam logic [7:0] OFS_RIGIDITY = 8'h1c;
  localparam logic [7:0] OFS_SPD_GAIN = 8'h20;
  localparam logic [7:0] OFS_SPD_INTEG = 8'h24;
  localparam logic [7:0] OFS_POS_GAIN = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_CMD = 8'h30;
  localparam logic [7:0] OFS_HIST0 = 8'h40;
  // function select values
  localparam logic [7:0] FSEL_JOG = 8'h00;
  localparam logic [7:0] FSEL_HIST_CLR = 8'h06;
  localparam logic [7:0] FSEL_RESET = 8'h00;
  // function control fields: mode switch select bits c/d, position disable bit b
  localparam int FCTRL_MS_LO = 12;
  localparam int FCTRL_MS_HI = 13;
  localparam int FCTRL_POS_DIS = 11;
  localparam logic [15:0] FCTRL_RESET = 16'h0000;
  // constant defaults and limits
  localparam logic [15:0] JOG_SPEED_RESET = 16'h01f4; // 500 r/min
  localparam logic [15:0] ACCEL_LVL_MAX = 16'h0bb8; // 3000
  localparam logic [15:0] ERR_LVL_MAX = 16'h2710; // 10000
  localparam logic [15:0] LVL_RESET = 16'h0000;
  localparam logic [2:0] RIGID_MIN = 3'h1;
  localparam logic [2:0] RIGID_MAX = 3'h7; // seven levels
  localparam logic [2:0] RIGID_RESET = 3'h4;
  // alarm codes
  localparam logic [7:0] ALM_NONE = 8'h99;
  localparam logic [7:0] ALM_LINK_ERR_ONE = 8'hf0;
  localparam logic [7:0] ALM_LINK_ERR_TWO = 8'hf1;
  localparam logic [7:0] ALM_ABS_DATA = 8'h00;
  localparam logic [7:0] ALM_CONST_BREAK = 8'h02;
  localparam logic [7:0] ALM_CONST_SET = 8'h04;
  localparam logic [7:0] ALM_OVERCURRENT = 8'h10;
  localparam logic [7:0] ALM_POS_ERR_OVF = 8'h31;
  localparam logic [7:0] ALM_OVERVOLTAGE = 8'h40;
  localparam logic [7:0] ALM_OVERSPEED = 8'h51;
  localparam logic [7:0] ALM_OVERLOAD = 8'h70;
  localparam logic [7:0] ALM_REF_READ = 8'hb1;
  localparam logic [7:0] ALM_OVERRUN = 8'hc1;
  localparam logic [7:0] ALM_POWER_LOSS = 8'hf3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // mode switch quantity select
  localparam logic [1:0] MS_TORQUE = 2'b00;
  localparam logic [1:0] MS_SPEED = 2'b01;
  localparam logic [1:0] MS_ACCEL = 2'b10;
  localparam logic [1:0] MS_ERR = 2'b11;
  // constant numbers walked on the panel
  localparam logic [1:0] CNUM_FSEL = 2'b00;
  localparam logic [1:0] CNUM_LAST = 2'b10;

  typedef enum logic [1:0] {
    PM_SET = 2'b00,
    PM_DATA = 2'b01,
    PM_JOG = 2'b10,
    PM_HIST = 2'b11
  } ahj_pmode_t;

  // keypad pins: up, down, servo toggle, mode, enter
  typedef struct packed {
    logic up;
    logic down;
    logic servo;
    logic mode;
    logic enter;
  } ahj_keys_t;

  // quantities from the servo core for the mode switch
  typedef struct packed {
    logic [15:0] torque;
    logic [15:0] speed;
    logic [15:0] accel;
    logic [15:0] err;
  } ahj_msq_t;
endpackage

/* ahj_panel.sv */
// Purpose: alarm history, keypad jog control, autotune constants, mode switch
// Assumes: keys and proportional_mode_input arrive as raw pins; core signals on clk_i
// Notes: registers over AXI4-Lite, one write and one read in flight
// Summary of operation
// R1: keep up to ten past alarm codes
// R2: position zero newest, larger positions older
// R3: alarm reset and drive power keep history; rst_b_i reset refills it with no-alarm codes
// R4: history-clear function or a CMD register write with bit 1 set erases history
// R5: history view: up/down step shown position
// R6: log all listed drive alarm classes
// R7: no-alarm code fills empty entries
// R8: keypad link errors never enter history
// R9: confirmed 00 enters jog; forced 00 at power-up
// R10: setting mode first shows function select constant
// R11: servo key toggles servo on and off
// R12: up forward, down reverse while held
// R13: leaving jog ends keypad motor control
// R14: jog speed from constant, default 500
// R15: autotune writes loop gain constants
// R16: rigidity limited to seven levels
// R17: host keeps proportional input off for tuning
// R18: mode switch forces P above level
// R19: select bits disable mode switch
// R20: accel level max 3000, error max 10000
// R21: two bits select compared quantity
// R22: full history shifts and drops oldest
//
// The address map and the AXI4-Lite register port were decided locally.
module ahj_panel
  import ahj_pkg::*;
#(
  parameter bit POS_VARIANT = 1'b0,
  parameter logic [15:0] SPD_GAIN_RESET = 16'h0028,
  parameter logic [15:0] SPD_INTEG_RESET = 16'h0014,
  parameter logic [15:0] POS_GAIN_RESET = 16'h0028
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // keypad and display
  input wire ahj_keys_t keys_i,
  output ahj_pmode_t disp_mode_o,
  output logic [3:0] disp_index_o,
  output logic [15:0] disp_data_o,
  // servo core
  input wire logic alarm_i,
  input wire logic [7:0] alarm_code_i,
  input wire logic alarm_reset_i,
  input wire logic proportional_mode_input_i,
  input wire ahj_msq_t msq_i,
  input wire logic tune_done_i,
  input wire logic [15:0] tune_spd_gain_i,
  input wire logic [15:0] tune_spd_integ_i,
  input wire logic [15:0] tune_pos_gain_i,
  output logic keypad_ctrl_o,
  output logic servo_on_o,
  output logic jog_fwd_o,
  output logic jog_rev_o,
  output logic [15:0] jog_speed_setting_o,
  output logic p_control_o,
  output logic tune_start_o,
  output logic [2:0] rigidity_o,
  output logic [15:0] speed_loop_gain_constant_o,
  output logic [15:0] speed_integral_time_constant_o,
  output logic [15:0] position_loop_gain_constant_o
);
  typedef struct packed {
    ahj_keys_t key_m;
    ahj_keys_t key_s;
    ahj_keys_t key_d;
    logic pmi_m;
    logic pmi_s;
    ahj_pmode_t pmode;
    logic [1:0] cnum;
    logic [3:0] hpos;
    logic [7:0] edit;
    logic [7:0] fsel;
    logic [15:0] fctrl;
    logic [15:0] jog_spd;
    logic [3:0][15:0] lvl;
    logic [2:0] rigid;
    logic [15:0] spd_gain;
    logic [15:0] spd_integ;
    logic [15:0] pos_gain;
    logic servo_on;
    logic tune_busy;
    logic tune_start;
    logic [7:0] cur_alarm;
    logic [HIST_DEPTH-1:0][7:0] hist;
    logic [3:0] hcnt;
    logic aw_full;
    logic [7:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ahj_state_t;
  ahj_state_t r;
  ahj_state_t next_r;
  // byte-lane merge of a write into a 32-bit image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) res[i*8 +: 8] = wd[i*8 +: 8];
    end
    return res;
  endfunction
  // clamp a level write to its ceiling
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
    return (v > lim) ? lim : v;
  endfunction
  logic ms_disabled;
  logic [15:0] ms_qty;
  logic [15:0] ms_lvl;
  ahj_keys_t key_rise;
  logic [7:0] waddr;
  logic [31:0] wimg;
  logic [15:0] wlo;
  logic [2:0] wrig;
  logic hist_clear;
  logic [3:0] hidx;
  // mode switch qualification, disable depends on the variant
  always_comb begin
    ms_disabled = POS_VARIANT ? r.fctrl[FCTRL_POS_DIS]
                : (r.fctrl[FCTRL_MS_HI] & r.fctrl[FCTRL_MS_LO]); // [R19]
    unique case (r.fctrl[FCTRL_MS_HI:FCTRL_MS_LO])
      MS_TORQUE: ms_qty = msq_i.torque; // [R21]
      MS_SPEED: ms_qty = msq_i.speed;
      MS_ACCEL: ms_qty = msq_i.accel;
      MS_ERR: ms_qty = msq_i.err;
    endcase
    ms_lvl = r.lvl[r.fctrl[FCTRL_MS_HI:FCTRL_MS_LO]];
  end
  // keys act on the press edge of the synchronised level
  assign key_rise = r.key_s & ~r.key_d;
  assign waddr = r.awaddr;
  assign hidx = 4'((waddr - OFS_HIST0) >> 2);
  always_comb begin
    next_r = r;
    next_r.key_m = keys_i;
    next_r.key_s = r.key_m;
    next_r.key_d = r.key_s;
    next_r.pmi_m = proportional_mode_input_i;
    next_r.pmi_s = r.pmi_m;
    next_r.tune_start = 1'b0;
    hist_clear = 1'b0;
    wimg = 32'h0000_0000;
    wlo = 16'h0000;
    wrig = RIGID_RESET;
    // keypad panel sequencing
    unique case (r.pmode)
      PM_SET: begin
        if (key_rise.mode) begin
          next_r.pmode = PM_HIST;
          next_r.hpos = 4'h0;
        end else if (key_rise.enter) begin
          next_r.pmode = PM_DATA;
          next_r.edit = r.fsel;
        end else if (key_rise.up && r.cnum != CNUM_LAST) next_r.cnum = r.cnum + 2'h1;
        else if (key_rise.down && r.cnum != CNUM_FSEL) next_r.cnum = r.cnum - 2'h1;
      end
      PM_DATA: begin
        if (key_rise.enter) begin
          next_r.pmode = PM_SET;
          if (r.cnum == CNUM_FSEL) begin
            next_r.fsel = r.edit;
            if (r.edit == FSEL_JOG) next_r.pmode = PM_JOG; // [R9]
            hist_clear = (r.edit == FSEL_HIST_CLR); // [R4]
          end
        end else if (key_rise.up && r.cnum == CNUM_FSEL) next_r.edit = r.edit + 8'h01;
        else if (key_rise.down && r.cnum == CNUM_FSEL) next_r.edit = r.edit - 8'h01;
      end
      PM_JOG: begin
        if (key_rise.enter) begin
          next_r.pmode = PM_SET; // [R13]
          next_r.servo_on = 1'b0; // [R13]
        end else if (key_rise.servo) next_r.servo_on = ~r.servo_on; // [R11]
      end
      PM_HIST: begin
        if (key_rise.mode) begin
          next_r.pmode = PM_SET;
        end else if (key_rise.up && r.hpos != 4'(HIST_DEPTH - 1)) begin
          next_r.hpos = r.hpos + 4'h1; // [R5]
        end else if (key_rise.down && r.hpos != 4'h0) begin
          next_r.hpos = r.hpos - 4'h1; // [R5]
        end
      end
    endcase
    // alarm reporting; history ignores alarm reset on purpose
    if (alarm_reset_i) next_r.cur_alarm = ALM_NONE; // [R7] [R3]
    if (alarm_i) begin
      next_r.cur_alarm = alarm_code_i; // [R8]
      if (alarm_code_i != ALM_LINK_ERR_ONE && alarm_code_i != ALM_LINK_ERR_TWO) begin
        // newest at zero, everything ages by one, oldest falls off
        next_r.hist = {r.hist[HIST_DEPTH-2:0], alarm_code_i}; // [R1] [R2] [R22] [R6]
        if (r.hcnt != 4'(HIST_DEPTH)) next_r.hcnt = r.hcnt + 4'h1; // [R1]
      end
    end
    // autotune completion loads the loop constants and drops the servo
    if (tune_done_i && r.tune_busy) begin
      next_r.tune_busy = 1'b0;
      next_r.servo_on = 1'b0;
      next_r.spd_gain = tune_spd_gain_i; // [R15]
      next_r.spd_integ = tune_spd_integ_i; // [R15]
      if (POS_VARIANT) next_r.pos_gain = tune_pos_gain_i; // [R15]
    end
    // axi write: address and data taken in either order
    if (s_axi_awvalid && !r.aw_full) begin
      next_r.aw_full = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_full) begin
      next_r.w_full = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.aw_full && r.w_full && !r.bvalid) begin
      next_r.aw_full = 1'b0;
      next_r.w_full = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      wimg = merge(32'h0000_0000, r.wdata, r.wstrb);
      wlo = wimg[15:0];
      unique case (waddr)
        OFS_FUNC_SEL: next_r.fsel = 8'(merge({24'h000000, r.fsel}, r.wdata, r.wstrb));
        OFS_FUNC_CTRL: next_r.fctrl = 16'(merge({16'h0000, r.fctrl}, r.wdata, r.wstrb));
        OFS_JOG_SPEED: next_r.jog_spd = 16'(merge({16'h0000, r.jog_spd}, r.wdata, r.wstrb));
        OFS_TORQUE_LVL: next_r.lvl[MS_TORQUE] = wlo;
        OFS_SPEED_LVL: next_r.lvl[MS_SPEED] = wlo;
        OFS_ACCEL_LVL: next_r.lvl[MS_ACCEL] = clamp(wlo, ACCEL_LVL_MAX); // [R20]
        OFS_ERR_LVL: next_r.lvl[MS_ERR] = clamp(wlo, ERR_LVL_MAX); // [R20]
        OFS_RIGIDITY: begin
          wrig = wimg[2:0];
          next_r.rigid = (wrig < RIGID_MIN) ? RIGID_MIN : wrig; // [R16]
        end
        OFS_SPD_GAIN: next_r.spd_gain = wlo;
        OFS_SPD_INTEG: next_r.spd_integ = wlo;
        OFS_POS_GAIN: next_r.pos_gain = wlo;
        OFS_CMD: begin
          // start refused while the proportional input is active
          if (wimg[0] && !r.tune_busy && !r.pmi_s) begin // [R17]
            next_r.tune_busy = 1'b1;
            next_r.tune_start = 1'b1;
          end
          hist_clear = hist_clear | wimg[1]; // [R4]
        end
        OFS_STATUS: ;
        default: begin
          if (!(waddr >= OFS_HIST0 && hidx < 4'(HIST_DEPTH) && waddr[1:0] == 2'b00)) begin
            next_r.bresp = RESP_SLVERR;
          end
        end
      endcase
    end
    if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;
    // clear wins over a same-cycle alarm: the operator asked for an empty log
    if (hist_clear) begin
      next_r.hist = {HIST_DEPTH{ALM_NONE}}; // [R4] [R7]
      next_r.hcnt = 4'h0;
    end
    // axi read
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFS_FUNC_SEL: next_r.rdata[7:0] = r.fsel;
        OFS_FUNC_CTRL: next_r.rdata[15:0] = r.fctrl;
        OFS_JOG_SPEED: next_r.rdata[15:0] = r.jog_spd;
        OFS_TORQUE_LVL: next_r.rdata[15:0] = r.lvl[MS_TORQUE];
        OFS_SPEED_LVL: next_r.rdata[15:0] = r.lvl[MS_SPEED];
        OFS_ACCEL_LVL: next_r.rdata[15:0] = r.lvl[MS_ACCEL];
        OFS_ERR_LVL: next_r.rdata[15:0] = r.lvl[MS_ERR];
        OFS_RIGIDITY: next_r.rdata[2:0] = r.rigid;
        OFS_SPD_GAIN: next_r.rdata[15:0] = r.spd_gain;
        OFS_SPD_INTEG: next_r.rdata[15:0] = r.spd_integ;
        OFS_POS_GAIN: next_r.rdata[15:0] = r.pos_gain;
        OFS_STATUS: next_r.rdata = {8'h00, r.cur_alarm, r.hcnt, r.hpos, 1'b0, p_control_o,
                                    r.tune_busy, r.servo_on, jog_fwd_o, jog_rev_o, r.pmode};
        OFS_CMD: ;
        default: begin
          if (s_axi_araddr >= OFS_HIST0 && s_axi_araddr[1:0] == 2'b00
              && 4'((s_axi_araddr - OFS_HIST0) >> 2) < 4'(HIST_DEPTH)) begin
            // entry tagged with its position in bits 11:8
            next_r.rdata[11:0] = {4'((s_axi_araddr - OFS_HIST0) >> 2),
                                  r.hist[4'((s_axi_araddr - OFS_HIST0) >> 2)]}; // [R1]
          end else begin
            next_r.rresp = RESP_SLVERR;
          end
        end
      endcase
    end else if (r.rvalid && s_axi_rready) next_r.rvalid = 1'b0;
  end
  // single state register; everything comes back to power-on values
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '0;
      r.pmode <= PM_SET;
      r.cnum <= CNUM_FSEL; // [R10]
      r.fsel <= FSEL_RESET; // [R9]
      r.fctrl <= FCTRL_RESET;
      r.jog_spd <= JOG_SPEED_RESET; // [R14]
      r.lvl <= {4{LVL_RESET}};
      r.rigid <= RIGID_RESET;
      r.spd_gain <= SPD_GAIN_RESET;
      r.spd_integ <= SPD_INTEG_RESET;
      r.pos_gain <= POS_GAIN_RESET;
      r.cur_alarm <= ALM_NONE; // [R7]
      r.hist <= {HIST_DEPTH{ALM_NONE}}; // [R7]
      r.bresp <= RESP_OKAY;
      r.rresp <= RESP_OKAY;
    end else begin
      r <= next_r;
    end
  end
  // bus handshakes
  assign s_axi_awready = ~r.aw_full;
  assign s_axi_wready = ~r.w_full;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = ~r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  // motor commands only while the panel owns the drive
  assign keypad_ctrl_o = (r.pmode == PM_JOG); // [R9] [R13]
  assign servo_on_o = r.servo_on; // [R11]
  assign jog_fwd_o = keypad_ctrl_o & r.servo_on & r.key_s.up & ~r.key_s.down; // [R12]
  assign jog_rev_o = keypad_ctrl_o & r.servo_on & r.key_s.down & ~r.key_s.up; // [R12]
  assign jog_speed_setting_o = r.jog_spd; // [R14]
  // level compare is combinational so the loop switches without a cycle of lag
  assign p_control_o = r.pmi_s | (~ms_disabled & (ms_qty > ms_lvl)); // [R18]
  assign tune_start_o = r.tune_start;
  assign rigidity_o = r.rigid; // [R16]
  assign speed_loop_gain_constant_o = r.spd_gain;
  assign speed_integral_time_constant_o = r.spd_integ;
  assign position_loop_gain_constant_o = r.pos_gain;
  // display: constant number, edited data, jog speed, or history entry
  assign disp_mode_o = r.pmode;
  assign disp_index_o = (r.pmode == PM_HIST) ? r.hpos : {2'b00, r.cnum};
  assign disp_data_o = (r.pmode == PM_HIST) ? {8'h00, r.hist[r.hpos]} // [R5]
                     : (r.pmode == PM_DATA) ? {8'h00, r.edit}
                     : (r.pmode == PM_JOG) ? r.jog_spd : {8'h00, r.fsel};
endmodule

/* ahj_panel_sva.sv */
// Purpose: port-level checks of the panel block
// Assumes: one clock domain, async active-low reset
// Notes: all checks sample on the rising edge
module ahj_panel_sva
  import ahj_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic proportional_mode_input_i,
  input wire ahj_msq_t msq_i,
  input wire ahj_pmode_t disp_mode_o,
  input wire logic keypad_ctrl_o,
  input wire logic servo_on_o,
  input wire logic jog_fwd_o,
  input wire logic jog_rev_o,
  input wire logic [15:0] jog_speed_setting_o,
  input wire logic p_control_o,
  input wire logic tune_start_o,
  input wire logic [2:0] rigidity_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // motion only under keypad control with servo on
  jog_gate_a: assert property ((jog_fwd_o || jog_rev_o) |-> keypad_ctrl_o && servo_on_o)
    else $error("jog output without control");
  jog_excl_a: assert property (!(jog_fwd_o && jog_rev_o))
    else $error("both jog directions");
  jog_speed_a: assert property ($rose(rst_b_i) |-> jog_speed_setting_o == 16'h01f4)
    else $error("jog speed default wrong");
  rigid_range_a: assert property (rigidity_o >= 3'h1)
    else $error("rigidity out of range");
  kctl_mode_a: assert property (keypad_ctrl_o == (disp_mode_o == PM_JOG))
    else $error("keypad control mismatch");
  jog_leave_a: assert property ($fell(keypad_ctrl_o) |-> !servo_on_o)
    else $error("servo left on after jog");
  servo_key_a: assert property ($rose(servo_on_o) |-> keypad_ctrl_o)
    else $error("servo on outside jog");
  tune_pulse_a: assert property (tune_start_o |=> !tune_start_o)
    else $error("tune start too long");
  // quiet quantities and inactive input keep pi control
  pi_hold_a: assert property ((msq_i == '0 && !proportional_mode_input_i)[*3] |-> !p_control_o)
    else $error("p control without cause");
  p_input_a: assert property (proportional_mode_input_i[*3] |-> p_control_o)
    else $error("p input ignored");
endmodule

bind ahj_panel ahj_panel_sva i_sva (.*);

/* ahj_core_model.sv */
// Purpose: servo core stand-in that answers autotune requests
// Assumes: tune start is a one-cycle pulse
// Notes: results are only valid during the done pulse
module ahj_core_model
  import ahj_pkg::*;
#(
  parameter logic [15:0] GAIN_S = 16'h0033,
  parameter logic [15:0] GAIN_I = 16'h0055,
  parameter logic [15:0] GAIN_P = 16'h0077
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic tune_start_i,
  input wire logic slow_i,
  output logic tune_done_o,
  output logic [15:0] spd_gain_o,
  output logic [15:0] integ_o,
  output logic [15:0] pos_gain_o
);
  logic [5:0] cnt;
  logic busy;
  // measure for a short or long time, then hand back gains
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy <= 1'b0;
      cnt <= '0;
      tune_done_o <= 1'b0;
      {spd_gain_o, integ_o, pos_gain_o} <= '0;
    end else begin
      tune_done_o <= 1'b0;
      // stale results flip so only the done pulse counts
      {spd_gain_o, integ_o, pos_gain_o} <= ~{spd_gain_o, integ_o, pos_gain_o};
      if (tune_start_i) begin
        busy <= 1'b1;
        cnt <= slow_i ? 6'h28 : 6'h02;
      end else if (busy && cnt == 6'h00) begin
        busy <= 1'b0;
        tune_done_o <= 1'b1;
        {spd_gain_o, integ_o, pos_gain_o} <= {GAIN_S, GAIN_I, GAIN_P};
      end else if (busy) begin
        cnt <= cnt - 6'h01;
      end
    end
  end
endmodule

/* tb_alarm_history_and_jog_control.sv */
// Purpose: self-checking bench for the panel block
// Assumes: speed variant, core model behind the tuning port
// Notes: history kept in a queue, newest first
module tb_alarm_history_and_jog_control import ahj_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, kctl, son, jf, jr, pctl, tstart, tdone;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  ahj_keys_t keys = '0;
  ahj_pmode_t mode;
  ahj_msq_t msq = '0;
  logic [3:0] didx;
  logic [15:0] ddata, jspd, g_s, g_i, g_p, t_s, t_i, t_p;
  logic [2:0] rig;
  logic alm = 1'b0, alm_rst = 1'b0, pmi = 1'b0, slow = 1'b0;
  logic [7:0] alm_code = '0;
  logic [7:0] hist[$];
  logic [7:0] codes[11] = '{ALM_ABS_DATA, ALM_CONST_BREAK, ALM_CONST_SET, ALM_OVERCURRENT,
    ALM_POS_ERR_OVF, ALM_OVERVOLTAGE, ALM_OVERSPEED, ALM_OVERLOAD, ALM_REF_READ, ALM_OVERRUN,
    ALM_POWER_LOSS};
  int err_total = 0;
  int comparisons = 0;
  logic [15:0] r;

  ahj_panel i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .keys_i(keys), .disp_mode_o(mode), .disp_index_o(didx),
    .disp_data_o(ddata), .alarm_i(alm), .alarm_code_i(alm_code), .alarm_reset_i(alm_rst),
    .proportional_mode_input_i(pmi), .msq_i(msq), .tune_done_i(tdone), .tune_spd_gain_i(t_s),
    .tune_spd_integ_i(t_i), .tune_pos_gain_i(t_p), .keypad_ctrl_o(kctl), .servo_on_o(son),
    .jog_fwd_o(jf), .jog_rev_o(jr), .jog_speed_setting_o(jspd), .p_control_o(pctl),
    .tune_start_o(tstart), .rigidity_o(rig), .speed_loop_gain_constant_o(g_s),
    .speed_integral_time_constant_o(g_i), .position_loop_gain_constant_o(g_p));
  ahj_core_model i_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .tune_start_i(tstart),
    .slow_i(slow), .tune_done_o(tdone), .spd_gain_o(t_s), .integ_o(t_i), .pos_gain_o(t_p));

  always #50 clk_i = ~clk_i;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a wait that ran out ends the run
  task hang();
    err_total++;
    give_verdict();
  endtask
  // one write, address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (ad && wd && bvalid) break;
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    if (n == 50) hang();
    chk(32'(bresp), 32'(er));
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (rvalid) break;
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (n == 50) hang();
    chk(rdata, exp);
    chk(32'(rresp), 32'(er));
  endtask
  // press and release one key: 0 up 1 down 2 servo 3 mode 4 enter
  task key(input int b);
    keys <= ahj_keys_t'(5'h10 >> b);
    repeat (6) @(posedge clk_i);
    keys <= '0;
    repeat (6) @(posedge clk_i);
  endtask
  task alarm(input logic [7:0] c);
    @(posedge clk_i);
    alm <= 1'b1;
    alm_code <= c;
    @(posedge clk_i);
    alm <= 1'b0;
    if (c != ALM_LINK_ERR_ONE && c != ALM_LINK_ERR_TWO) hist.push_front(c);
    if (hist.size() > HIST_DEPTH) void'(hist.pop_back());
  endtask
  task hist_chk();
    for (int i = 0; i < HIST_DEPTH; i++)
      rd(OFS_HIST0 + 8'(4 * i), {20'h0, 4'(i), (i < hist.size()) ? hist[i] : ALM_NONE}, RESP_OKAY);
  endtask

  initial begin
    void'($urandom(7));
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(OFS_FUNC_SEL, 32'h0, RESP_OKAY);
    rd(OFS_JOG_SPEED, 32'h1f4, RESP_OKAY);
    chk(32'(mode), 32'(PM_SET));
    chk(32'(didx), 32'h0);
    hist_chk();
    $display("reset test done");
    // every logged class (eleven, already past the ten entries), both link errors, one random extra
    for (int i = 0; i < 11; i++) alarm(codes[i]);
    alarm(ALM_LINK_ERR_ONE);
    alarm(ALM_LINK_ERR_TWO);
    alarm(codes[$urandom_range(10)]);
    hist_chk();
    @(posedge clk_i);
    alm_rst <= 1'b1;
    @(posedge clk_i);
    alm_rst <= 1'b0;
    hist_chk();
    $display("history test done");
    key(3);
    chk(32'(mode), 32'(PM_HIST));
    key(0);
    chk(32'(didx), 32'h1);
    chk(32'(ddata[7:0]), 32'(hist[1]));
    key(1);
    chk(32'(didx), 32'h0);
    key(3);
    chk(32'(didx), 32'h0);
    wr(OFS_CMD, 32'h2, RESP_OKAY);
    hist.delete();
    hist_chk();
    $display("view and clear test done");
    key(4);
    key(4);
    chk(32'(kctl), 32'h1);
    key(2);
    chk(32'(son), 32'h1);
    for (int b = 0; b < 2; b++) begin
      keys <= ahj_keys_t'(5'h10 >> b);
      repeat (6) @(posedge clk_i);
      chk({jf, jr}, 32'(b == 0 ? 2 : 1));
      keys <= '0;
      repeat (6) @(posedge clk_i);
      chk({jf, jr}, 32'h0);
    end
    key(2);
    chk(32'(son), 32'h0);
    key(2);
    key(4);
    chk({kctl, son}, 32'h0);
    $display("jog test done");
    r = 16'($urandom_range(1, 6000));
    wr(OFS_JOG_SPEED, 32'(r), RESP_OKAY);
    chk(32'(jspd), 32'(r));
    wr(OFS_RIGIDITY, 32'h0, RESP_OKAY);
    chk(32'(rig), 32'h1);
    wr(OFS_RIGIDITY, 32'h7, RESP_OKAY);
    chk(32'(rig), 32'h7);
    wr(OFS_ACCEL_LVL, 32'd4000, RESP_OKAY);
    rd(OFS_ACCEL_LVL, 32'd3000, RESP_OKAY);
    wr(OFS_ERR_LVL, 32'd20000, RESP_OKAY);
    rd(OFS_ERR_LVL, 32'd10000, RESP_OKAY);
    rd(8'h38, 32'h0, RESP_SLVERR);
    wr(8'h3c, 32'h1, RESP_SLVERR);
    // each quantity; both select bits set disables
    for (int s = 0; s < 4; s++) begin
      wr(OFS_FUNC_CTRL, 32'(s) << 12, RESP_OKAY);
      wr(OFS_TORQUE_LVL + 8'(4 * s), 32'd100, RESP_OKAY);
      msq <= ahj_msq_t'(64'd200 << (48 - 16 * s));
      repeat (2) @(posedge clk_i);
      chk(32'(pctl), 32'(s != 3));
      msq <= '0;
    end
    pmi <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(32'(pctl), 32'h1);
    pmi <= 1'b0;
    $display("constant test done");
    // proportional input stays low before each tuning run
    for (int t = 0; t < 2; t++) begin
      slow <= t[0];
      wr(OFS_CMD, 32'h1, RESP_OKAY);
      for (int n = 0; n <= 100 && !tdone; n++) begin
        @(posedge clk_i);
        if (n == 100) hang();
      end
      repeat (2) @(posedge clk_i);
      chk({g_s, g_i}, 32'h00330055);
      chk(32'(g_p), 32'h0028);
    end
    $display("tune test done");
    give_verdict();
  end
endmodule
